// ### src/port_alt_function_mux_pkg.sv
// Constants shared by the port alternate-function multiplexer and its bench.
`default_nettype none
package port_alt_function_mux_pkg;
  // Bus widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int GROUP_CNT = 4;

  // Pin group indices, which are also bits [5:4] of the byte address.
  localparam logic [1:0] GRP_CTRL = 2'h0;
  localparam logic [1:0] GRP_STROBE = 2'h1;
  localparam logic [1:0] GRP_UPPER = 2'h2;
  localparam logic [1:0] GRP_LOW = 2'h3;

  // Register kinds inside a group, bits [3:2] of the byte address.
  localparam logic [1:0] KIND_DATA = 2'h0;
  localparam logic [1:0] KIND_DIR = 2'h1;
  localparam logic [1:0] KIND_MODE = 2'h2;
  localparam logic [1:0] KIND_OD = 2'h3;

  // Byte offsets of each register.
  localparam logic [7:0] CTRL_DATA_OFS = 8'h00;
  localparam logic [7:0] CTRL_DIR_OFS = 8'h04;
  localparam logic [7:0] CTRL_MODE_OFS = 8'h08;
  localparam logic [7:0] STROBE_DATA_OFS = 8'h10;
  localparam logic [7:0] STROBE_DIR_OFS = 8'h14;
  localparam logic [7:0] STROBE_MODE_OFS = 8'h18;
  localparam logic [7:0] UPPER_DATA_OFS = 8'h20;
  localparam logic [7:0] UPPER_DIR_OFS = 8'h24;
  localparam logic [7:0] UPPER_MODE_OFS = 8'h28;
  localparam logic [7:0] LOW_DATA_OFS = 8'h30;
  localparam logic [7:0] LOW_DIR_OFS = 8'h34;
  localparam logic [7:0] LOW_MODE_OFS = 8'h38;
  localparam logic [7:0] LOW_OD_OFS = 8'h3c;
  localparam logic [7:0] MAP_END = 8'h40;

  // Implemented pin bits of each group.
  localparam logic [15:0] CTRL_PIN_MASK = 16'h000f;
  localparam logic [15:0] STROBE_PIN_MASK = 16'h00ff;
  localparam logic [15:0] UPPER_PIN_MASK = 16'h0003;
  localparam logic [15:0] LOW_PIN_MASK = 16'hffff;

  // Pin bits that own an alternate function, so their mode bit exists.
  localparam logic [15:0] CTRL_ALT_MASK = 16'h000f;
  localparam logic [15:0] STROBE_ALT_MASK = 16'h0053;
  localparam logic [15:0] UPPER_ALT_MASK = 16'h0003;
  localparam logic [15:0] LOW_ALT_MASK = 16'hffff;

  // Field positions of single alternate functions.
  localparam int CTRL_WAIT_BIT = 0;
  localparam int CTRL_CLOCK_BIT = 1;
  localparam int CTRL_HOLD_ACK_BIT = 2;
  localparam int CTRL_HOLD_REQ_BIT = 3;
  localparam int STROBE_WR_LOW_BIT = 0;
  localparam int STROBE_WR_HIGH_BIT = 1;
  localparam int STROBE_RD_BIT = 4;
  localparam int STROBE_ADDRESS_STROBE_BIT = 6;
  localparam int LOW_FLASH_MODE_BIT = 5;

  // Reset values: latches low, all pins inputs, port mode, push-pull.
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] DIR_RST = 16'hffff;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] OD_RST = 16'h0000;
endpackage : port_alt_function_mux_pkg
`default_nettype wire

// ### src/port_alt_function_mux.sv
// Pin multiplexer between port registers and external bus signals, with an APB slave.
//
// Register access over APB and the register offsets are this design's own decisions.
`default_nettype none

module port_alt_function_mux (
  // Clock, reset and clock enable.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [port_alt_function_mux_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [port_alt_function_mux_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [port_alt_function_mux_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Signals from the external bus controller.
  input wire logic bus_clock_i,
  input wire logic hold_acknowledge_out_i,
  input wire logic write_strobe_low_i,
  input wire logic write_strobe_high_i,
  input wire logic read_strobe_i,
  input wire logic address_strobe_i,
  input wire logic [1:0] upper_address_i,
  input wire logic [15:0] muxed_addr_data_out_i,
  input wire logic muxed_addr_data_oe_n_i,
  // Signals to the external bus controller and flash logic.
  output logic bus_wait_o,
  output logic hold_request_in_o,
  output logic [15:0] muxed_addr_data_in_o,
  output logic flash_prog_mode_in_o,
  // Control group pins.
  input wire logic [3:0] ctrl_pin_i,
  output logic [3:0] ctrl_pin_o,
  output logic [3:0] ctrl_pin_oe_n_o,
  // Strobe group pins.
  input wire logic [7:0] strobe_pin_i,
  output logic [7:0] strobe_pin_o,
  output logic [7:0] strobe_pin_oe_n_o,
  // Upper address group pins.
  input wire logic [1:0] upper_addr_pin_i,
  output logic [1:0] upper_addr_pin_o,
  output logic [1:0] upper_addr_pin_oe_n_o,
  // Low address/data group pins.
  input wire logic [15:0] low_pin_i,
  output logic [15:0] low_pin_o,
  output logic [15:0] low_pin_oe_n_o
);
  import port_alt_function_mux_pkg::*;

  // Register file, one entry per pin group.
  logic [REG_W-1:0] port_data_reg_r [GROUP_CNT];
  logic [REG_W-1:0] port_data_reg_nxt [GROUP_CNT];
  logic [REG_W-1:0] port_direction_reg_r [GROUP_CNT];
  logic [REG_W-1:0] port_direction_reg_nxt [GROUP_CNT];
  logic [REG_W-1:0] pin_mode_control_reg_r [GROUP_CNT];
  logic [REG_W-1:0] pin_mode_control_reg_nxt [GROUP_CNT];
  // Open-drain selection exists only on the low group.
  logic [REG_W-1:0] open_drain_select_reg_r;
  logic [REG_W-1:0] open_drain_select_reg_nxt;

  // APB answer registers.
  logic [DATA_W-1:0] prdata_r;
  logic [DATA_W-1:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  // Pin and bus-side output registers.
  logic [REG_W-1:0] pin_out_r [GROUP_CNT];
  logic [REG_W-1:0] pin_out_nxt [GROUP_CNT];
  logic [REG_W-1:0] pin_oe_n_r [GROUP_CNT];
  logic [REG_W-1:0] pin_oe_n_nxt [GROUP_CNT];
  logic bus_wait_r;
  logic bus_wait_nxt;
  logic hold_request_r;
  logic hold_request_nxt;
  logic [15:0] ad_in_r;
  logic [15:0] ad_in_nxt;
  logic flash_mode_r;
  logic flash_mode_nxt;

  // Combinational helpers.
  logic [REG_W-1:0] pin_level [GROUP_CNT];
  logic [REG_W-1:0] pin_mask [GROUP_CNT];
  logic [REG_W-1:0] alt_mask [GROUP_CNT];
  logic [REG_W-1:0] alt_out [GROUP_CNT];
  logic [REG_W-1:0] alt_oe_n [GROUP_CNT];
  logic [REG_W-1:0] od_sel [GROUP_CNT];
  logic [1:0] acc_grp;
  logic [1:0] acc_kind;
  logic acc_mapped;
  logic acc_commit;
  logic [REG_W-1:0] wr_lanes;

  // True when the byte address names an existing register.
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    addr_mapped = (addr < MAP_END) && (addr[1:0] == 2'h0) &&
                  ((addr[3:2] != KIND_OD) || (addr[5:4] == GRP_LOW));
  endfunction : addr_mapped

  // Read value of a data register: latch for outputs, pin level for inputs.
  function automatic logic [REG_W-1:0] data_view(input logic [REG_W-1:0] latch,
                                                 input logic [REG_W-1:0] dir,
                                                 input logic [REG_W-1:0] lvl);
    data_view = (latch & ~dir) | (lvl & dir);
  endfunction : data_view

  // Next value of a pin, packed as {oe_n, out}.
  function automatic logic [2*REG_W-1:0] pin_drive(input logic [REG_W-1:0] mode,
                                                   input logic [REG_W-1:0] latch,
                                                   input logic [REG_W-1:0] dir,
                                                   input logic [REG_W-1:0] od,
                                                   input logic [REG_W-1:0] a_out,
                                                   input logic [REG_W-1:0] a_oe_n);
    logic [REG_W-1:0] port_oe_n;
    port_oe_n = dir | (od & latch & ~dir);
    pin_drive = {(a_oe_n & mode) | (port_oe_n & ~mode),
                 (a_out & mode) | (latch & ~mode)};
  endfunction : pin_drive

  // Gathers pin levels, masks and alternate-function sources per group.
  always_comb begin
    pin_level[GRP_CTRL] = {12'h000, ctrl_pin_i};
    pin_level[GRP_STROBE] = {8'h00, strobe_pin_i};
    pin_level[GRP_UPPER] = {14'h0000, upper_addr_pin_i};
    pin_level[GRP_LOW] = low_pin_i;
    pin_mask[GRP_CTRL] = CTRL_PIN_MASK;
    pin_mask[GRP_STROBE] = STROBE_PIN_MASK;
    pin_mask[GRP_UPPER] = UPPER_PIN_MASK;
    pin_mask[GRP_LOW] = LOW_PIN_MASK;
    alt_mask[GRP_CTRL] = CTRL_ALT_MASK;
    alt_mask[GRP_STROBE] = STROBE_ALT_MASK;
    alt_mask[GRP_UPPER] = UPPER_ALT_MASK;
    alt_mask[GRP_LOW] = LOW_ALT_MASK;
    // Control group: wait and hold request are inputs, the other two outputs.
    alt_out[GRP_CTRL] = 16'h0000;
    alt_out[GRP_CTRL][CTRL_CLOCK_BIT] = bus_clock_i;
    alt_out[GRP_CTRL][CTRL_HOLD_ACK_BIT] = hold_acknowledge_out_i;
    alt_oe_n[GRP_CTRL] = 16'hffff;
    alt_oe_n[GRP_CTRL][CTRL_CLOCK_BIT] = 1'b0;
    alt_oe_n[GRP_CTRL][CTRL_HOLD_ACK_BIT] = 1'b0;
    // Strobe group: all four alternate functions are outputs.
    alt_out[GRP_STROBE] = 16'h0000;
    alt_out[GRP_STROBE][STROBE_WR_LOW_BIT] = write_strobe_low_i;
    alt_out[GRP_STROBE][STROBE_WR_HIGH_BIT] = write_strobe_high_i;
    alt_out[GRP_STROBE][STROBE_RD_BIT] = read_strobe_i;
    alt_out[GRP_STROBE][STROBE_ADDRESS_STROBE_BIT] = address_strobe_i;
    alt_oe_n[GRP_STROBE] = ~STROBE_ALT_MASK;
    // Upper group: address lines are plain outputs.
    alt_out[GRP_UPPER] = {14'h0000, upper_address_i};
    alt_oe_n[GRP_UPPER] = ~UPPER_ALT_MASK;
    // Low group: the bus controller alone decides the direction.
    alt_out[GRP_LOW] = muxed_addr_data_out_i;
    alt_oe_n[GRP_LOW] = {REG_W{muxed_addr_data_oe_n_i}};
    // Only the low group has an open-drain selection.
    od_sel[GRP_CTRL] = 16'h0000;
    od_sel[GRP_STROBE] = 16'h0000;
    od_sel[GRP_UPPER] = 16'h0000;
    od_sel[GRP_LOW] = open_drain_select_reg_r;
  end

  // Decodes the current APB access.
  always_comb begin
    acc_grp = paddr_i[5:4];
    acc_kind = paddr_i[3:2];
    acc_mapped = addr_mapped(paddr_i);
    // A write takes effect at the edge where pready is seen high; a read samples at the edge where pready rises.
    acc_commit = psel_i && penable_i && pready_r;
    wr_lanes = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  end

  // Next state of the register file.
  always_comb begin
    open_drain_select_reg_nxt = open_drain_select_reg_r;
    for (int g = 0; g < GROUP_CNT; g++) begin
      port_data_reg_nxt[g] = port_data_reg_r[g];
      port_direction_reg_nxt[g] = port_direction_reg_r[g];
      pin_mode_control_reg_nxt[g] = pin_mode_control_reg_r[g];
    end
    if (acc_commit && pwrite_i && acc_mapped) begin
      case (acc_kind)
        // Data writes always land in the latch, in either mode.
        KIND_DATA: begin
          port_data_reg_nxt[acc_grp] = ((pwdata_i[REG_W-1:0] & wr_lanes) |
            (port_data_reg_r[acc_grp] & ~wr_lanes)) & pin_mask[acc_grp];
        end
        // Direction bits steer only the port function.
        KIND_DIR: begin
          port_direction_reg_nxt[acc_grp] = ((pwdata_i[REG_W-1:0] & wr_lanes) |
            (port_direction_reg_r[acc_grp] & ~wr_lanes)) & pin_mask[acc_grp];
        end
        // Mode bits exist only where an alternate function does.
        KIND_MODE: begin
          pin_mode_control_reg_nxt[acc_grp] = ((pwdata_i[REG_W-1:0] & wr_lanes) |
            (pin_mode_control_reg_r[acc_grp] & ~wr_lanes)) & alt_mask[acc_grp];
        end
        // Open-drain selection of the low group.
        KIND_OD: begin
          open_drain_select_reg_nxt = (pwdata_i[REG_W-1:0] & wr_lanes) |
            (open_drain_select_reg_r & ~wr_lanes);
        end
        default: begin
          open_drain_select_reg_nxt = open_drain_select_reg_r;
        end
      endcase
    end
  end

  // Registers the register file; mode and open-drain start at zero.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int g = 0; g < GROUP_CNT; g++) begin
        port_data_reg_r[g] <= DATA_RST;
        port_direction_reg_r[g] <= DIR_RST & pin_mask_rst(g);
        pin_mode_control_reg_r[g] <= MODE_RST;
      end
      open_drain_select_reg_r <= OD_RST;
    end else if (ce_i) begin
      for (int g = 0; g < GROUP_CNT; g++) begin
        port_data_reg_r[g] <= port_data_reg_nxt[g];
        port_direction_reg_r[g] <= port_direction_reg_nxt[g];
        pin_mode_control_reg_r[g] <= pin_mode_control_reg_nxt[g];
      end
      open_drain_select_reg_r <= open_drain_select_reg_nxt;
    end
  end

  // Constant pin mask of a group, usable under reset.
  function automatic logic [REG_W-1:0] pin_mask_rst(input int g);
    case (g)
      0: pin_mask_rst = CTRL_PIN_MASK;
      1: pin_mask_rst = STROBE_PIN_MASK;
      2: pin_mask_rst = UPPER_PIN_MASK;
      default: pin_mask_rst = LOW_PIN_MASK;
    endcase
  endfunction : pin_mask_rst

  // Next APB answer: one wait state, read data prepared before pready rises.
  always_comb begin
    pready_nxt = psel_i && penable_i && !pready_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (pready_nxt) begin
      prdata_nxt = '0;
      pslverr_nxt = !acc_mapped;
      if (acc_mapped && !pwrite_i) begin
        case (acc_kind)
          // Output pins read the latch, input pins read the pin.
          KIND_DATA: begin
            prdata_nxt[REG_W-1:0] = data_view(port_data_reg_r[acc_grp],
              port_direction_reg_r[acc_grp], pin_level[acc_grp]) & pin_mask[acc_grp];
          end
          KIND_DIR: begin
            prdata_nxt[REG_W-1:0] = port_direction_reg_r[acc_grp];
          end
          KIND_MODE: begin
            prdata_nxt[REG_W-1:0] = pin_mode_control_reg_r[acc_grp];
          end
          KIND_OD: begin
            prdata_nxt[REG_W-1:0] = open_drain_select_reg_r;
          end
          default: begin
            prdata_nxt = '0;
          end
        endcase
      end
    end
  end

  // Registers the APB answer.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce_i) begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Next pin drive and next values towards the bus controller.
  always_comb begin
    for (int g = 0; g < GROUP_CNT; g++) begin
      {pin_oe_n_nxt[g], pin_out_nxt[g]} = pin_drive(pin_mode_control_reg_r[g],
        port_data_reg_r[g], port_direction_reg_r[g], od_sel[g], alt_out[g], alt_oe_n[g]);
      pin_oe_n_nxt[g] = pin_oe_n_nxt[g] | ~pin_mask[g];
      pin_out_nxt[g] = pin_out_nxt[g] & pin_mask[g];
    end
    // Alternate inputs read low while their pin is in port mode.
    bus_wait_nxt = ctrl_pin_i[CTRL_WAIT_BIT] &
                   pin_mode_control_reg_r[GRP_CTRL][CTRL_WAIT_BIT];
    hold_request_nxt = ctrl_pin_i[CTRL_HOLD_REQ_BIT] &
                       pin_mode_control_reg_r[GRP_CTRL][CTRL_HOLD_REQ_BIT];
    ad_in_nxt = low_pin_i & pin_mode_control_reg_r[GRP_LOW];
    // The flash mode input bypasses every port setting.
    flash_mode_nxt = low_pin_i[LOW_FLASH_MODE_BIT];
  end

  // Registers pins and bus-side signals; pins float as inputs at reset.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int g = 0; g < GROUP_CNT; g++) begin
        pin_out_r[g] <= '0;
        pin_oe_n_r[g] <= '1;
      end
      bus_wait_r <= 1'b0;
      hold_request_r <= 1'b0;
      ad_in_r <= '0;
      flash_mode_r <= 1'b0;
    end else if (ce_i) begin
      for (int g = 0; g < GROUP_CNT; g++) begin
        pin_out_r[g] <= pin_out_nxt[g];
        pin_oe_n_r[g] <= pin_oe_n_nxt[g];
      end
      bus_wait_r <= bus_wait_nxt;
      hold_request_r <= hold_request_nxt;
      ad_in_r <= ad_in_nxt;
      flash_mode_r <= flash_mode_nxt;
    end
  end

  // Output wiring straight from the registers.
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign bus_wait_o = bus_wait_r;
  assign hold_request_in_o = hold_request_r;
  assign muxed_addr_data_in_o = ad_in_r;
  assign flash_prog_mode_in_o = flash_mode_r;
  assign ctrl_pin_o = pin_out_r[GRP_CTRL][3:0];
  assign ctrl_pin_oe_n_o = pin_oe_n_r[GRP_CTRL][3:0];
  assign strobe_pin_o = pin_out_r[GRP_STROBE][7:0];
  assign strobe_pin_oe_n_o = pin_oe_n_r[GRP_STROBE][7:0];
  assign upper_addr_pin_o = pin_out_r[GRP_UPPER][1:0];
  assign upper_addr_pin_oe_n_o = pin_oe_n_r[GRP_UPPER][1:0];
  assign low_pin_o = pin_out_r[GRP_LOW];
  assign low_pin_oe_n_o = pin_oe_n_r[GRP_LOW];
endmodule : port_alt_function_mux
`default_nettype wire

// ### tb/port_alt_function_mux_sva.sv
// Concurrent checks on the pin multiplexer's pin outputs and APB answers.
`default_nettype none
module port_alt_function_mux_sva import port_alt_function_mux_pkg::*; (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // APB slave signals.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Bus controller side.
  input wire logic [1:0] upper_address_i,
  input wire logic [15:0] muxed_addr_data_out_i,
  input wire logic muxed_addr_data_oe_n_i,
  input wire logic bus_wait_o,
  input wire logic hold_request_in_o,
  input wire logic [15:0] muxed_addr_data_in_o,
  input wire logic flash_prog_mode_in_o,
  // Pins.
  input wire logic [3:0] ctrl_pin_i,
  input wire logic [1:0] upper_addr_pin_o,
  input wire logic [1:0] upper_addr_pin_oe_n_o,
  input wire logic [15:0] low_pin_i,
  input wire logic [15:0] low_pin_o,
  input wire logic [15:0] low_pin_oe_n_o
);
  // Mirror of the low and upper mode registers, which the pins do not show.
  logic [15:0] low_mode_r, low_mode_nxt;
  logic [1:0] up_mode_r, up_mode_nxt;
  logic wr_ok;
  assign wr_ok = psel_i && penable_i && pwrite_i && pready_o && !pslverr_o;
  // Only an accepted write to the matching offset changes the mirror.
  always_comb begin
    low_mode_nxt = low_mode_r;
    up_mode_nxt = up_mode_r;
    if (wr_ok && paddr_i == LOW_MODE_OFS) begin
      low_mode_nxt = pwdata_i[15:0];
    end
    if (wr_ok && paddr_i == UPPER_MODE_OFS) begin
      up_mode_nxt = pwdata_i[1:0];
    end
  end
  // Mirror flops clear on reset, as the real mode registers do.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_mode_r <= 16'h0000;
      up_mode_r <= 2'h0;
    end else begin
      low_mode_r <= low_mode_nxt;
      up_mode_r <= up_mode_nxt;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_flash_follow: assert property ($past(reset_n_i) |->
    flash_prog_mode_in_o == $past(low_pin_i[5])) else $error("flash input not following pin");
  a_wait_gated: assert property ($past(reset_n_i) && bus_wait_o |->
    $past(ctrl_pin_i[0])) else $error("wait raised without pin");
  a_hold_gated: assert property ($past(reset_n_i) && hold_request_in_o |->
    $past(ctrl_pin_i[3])) else $error("hold request raised without pin");
  a_upper_drive: assert property ($past(reset_n_i) |->
    ((upper_addr_pin_o ^ $past(upper_address_i)) & $past(up_mode_r)) == 2'h0
    && (upper_addr_pin_oe_n_o & $past(up_mode_r)) == 2'h0) else $error("upper address pin wrong");
  a_ad_out_drive: assert property ($past(reset_n_i) |->
    ((low_pin_o ^ $past(muxed_addr_data_out_i)) & $past(low_mode_r)) == 16'h0000
    && ((low_pin_oe_n_o ^ {16{$past(muxed_addr_data_oe_n_i)}}) & $past(low_mode_r)) == 16'h0000)
    else $error("address/data pin not bus driven");
  a_ad_in_gate: assert property ($past(reset_n_i) |->
    muxed_addr_data_in_o == ($past(low_pin_i) & $past(low_mode_r))) else $error("ad input gate wrong");
  a_ready_one_wait: assert property ($rose(psel_i && penable_i) |=> pready_o)
    else $error("answer not after one wait state");
  a_ready_pulse: assert property (pready_o |-> psel_i && penable_i &&
    $past(psel_i && penable_i) ##1 !pready_o) else $error("ready outside access or too long");
  a_err_unmapped: assert property (pready_o && paddr_i >= MAP_END |-> pslverr_o)
    else $error("unmapped access not refused");
  a_err_with_ready: assert property (pslverr_o |-> pready_o && prdata_o[31:16] == 16'h0000)
    else $error("error without ready or high data bits set");
endmodule : port_alt_function_mux_sva
bind port_alt_function_mux port_alt_function_mux_sva u_port_alt_function_mux_sva (
  .clk_sys_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .pready_o, .pslverr_o, .upper_address_i, .muxed_addr_data_out_i, .muxed_addr_data_oe_n_i,
  .bus_wait_o, .hold_request_in_o, .muxed_addr_data_in_o, .flash_prog_mode_in_o, .ctrl_pin_i,
  .upper_addr_pin_o, .upper_addr_pin_oe_n_o, .low_pin_i, .low_pin_o, .low_pin_oe_n_o);
`default_nettype wire

// ### tb/port_alt_function_mux_tb.sv
// Self-checking bench for the port alternate-function multiplexer.
`default_nettype none
module port_alt_function_mux_tb;
  import port_alt_function_mux_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // Stimulus held by the bench; byte strobes stay tied on, clock enable drops once.
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, bus_clock_i = 1'b0, hold_acknowledge_out_i = 1'b0;
  logic write_strobe_low_i = 1'b0, write_strobe_high_i = 1'b0, read_strobe_i = 1'b0;
  logic address_strobe_i = 1'b0, muxed_addr_data_oe_n_i = 1'b1;
  logic [7:0] paddr_i = 8'h00, strobe_pin_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'hf, ctrl_pin_i = 4'h0;
  logic [1:0] upper_address_i = 2'h0, upper_addr_pin_i = 2'h0;
  logic [15:0] muxed_addr_data_out_i = 16'h0000, low_pin_i = 16'h0000;
  // Outputs of the block.
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, bus_wait_o, hold_request_in_o, flash_prog_mode_in_o;
  logic [15:0] muxed_addr_data_in_o, low_pin_o, low_pin_oe_n_o;
  logic [3:0] ctrl_pin_o, ctrl_pin_oe_n_o;
  logic [7:0] strobe_pin_o, strobe_pin_oe_n_o;
  logic [1:0] upper_addr_pin_o, upper_addr_pin_oe_n_o;
  int error_cnt = 0, checks_done = 0;
  logic [31:0] rdata;
  logic err;

  // The 20 MHz system clock.
  always #25 clk_sys_i = ~clk_sys_i;

  port_alt_function_mux u_port_alt_function_mux (
    .clk_sys_i, .reset_n_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .pready_o, .pslverr_o, .bus_clock_i, .hold_acknowledge_out_i, .write_strobe_low_i,
    .write_strobe_high_i, .read_strobe_i, .address_strobe_i, .upper_address_i,
    .muxed_addr_data_out_i, .muxed_addr_data_oe_n_i, .bus_wait_o, .hold_request_in_o,
    .muxed_addr_data_in_o, .flash_prog_mode_in_o, .ctrl_pin_i, .ctrl_pin_o, .ctrl_pin_oe_n_o,
    .strobe_pin_i, .strobe_pin_o, .strobe_pin_oe_n_o, .upper_addr_pin_i, .upper_addr_pin_o,
    .upper_addr_pin_oe_n_o, .low_pin_i, .low_pin_o, .low_pin_oe_n_o);

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test;
    $display("Mismatches %0d, comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Compares a seen value with the expected one and counts the outcome.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // One APB transfer: setup, then access held until ready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk(1'b0, 1'b1, "apb ready timeout");
      end_of_test();
    end
    rdata = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // Lets a register or pin change reach the registered pin outputs.
  task automatic settle;
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask : settle

  // Reset state: control and low pins float, every mode register reads zero, flash input follows.
  task automatic t_reset;
    logic [7:0] ofs [5];
    ofs = '{CTRL_MODE_OFS, STROBE_MODE_OFS, UPPER_MODE_OFS, LOW_MODE_OFS, LOW_OD_OFS};
    settle();
    chk(ctrl_pin_oe_n_o, 4'hf, "ctrl oe after reset");
    chk(low_pin_oe_n_o, 16'hffff, "low oe after reset");
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rdata, 32'h0, "mode reset value");
    end
    @(posedge clk_sys_i);
    low_pin_i <= 16'h0020;
    settle();
    chk(flash_prog_mode_in_o, 1'b1, "flash mode input");
  endtask : t_reset

  // Port mode on the low group: latch driven by direction, open-drain, mixed read.
  task automatic t_port;
    apb(1'b1, LOW_DATA_OFS, 32'ha5c3);
    apb(1'b1, LOW_DIR_OFS, 32'hff00);
    apb(1'b1, LOW_OD_OFS, 32'h0001);
    @(posedge clk_sys_i);
    low_pin_i <= 16'h5a00;
    settle();
    chk(low_pin_oe_n_o, 16'hff01, "port mode enables");
    chk(low_pin_o & 16'h00ff, 16'h00c3, "port mode latch out");
    apb(1'b0, LOW_DATA_OFS, 32'h0);
    chk(rdata, 32'h5ac3, "latch and pin read");
  endtask : t_port

  // Alternate mode on the low group: bus owns the pins in both directions.
  task automatic t_alt_low;
    @(posedge clk_sys_i);
    muxed_addr_data_out_i <= 16'h1234;
    muxed_addr_data_oe_n_i <= 1'b0;
    apb(1'b1, LOW_MODE_OFS, 32'hffff);
    settle();
    chk(low_pin_o, 16'h1234, "bus address out");
    chk(low_pin_oe_n_o, 16'h0000, "bus drives all");
    chk(muxed_addr_data_in_o, 16'h5a00, "bus data in");
    @(posedge clk_sys_i);
    muxed_addr_data_oe_n_i <= 1'b1;
    low_pin_i <= 16'hbeef;
    settle();
    chk(low_pin_oe_n_o, 16'hffff, "bus releases pins");
    chk(muxed_addr_data_in_o, 16'hbeef, "bus data in");
    apb(1'b0, LOW_DATA_OFS, 32'h0);
    chk(rdata, 32'hbec3, "read in alternate mode");
    apb(1'b1, LOW_MODE_OFS, 32'h0);
    settle();
    chk(muxed_addr_data_in_o, 16'h0000, "input gated in port mode");
    chk(low_pin_oe_n_o, 16'hff01, "back to port mode");
  endtask : t_alt_low

  // Control, strobe and upper groups in alternate mode, then control back to port.
  task automatic t_ext;
    @(posedge clk_sys_i);
    ctrl_pin_i <= 4'h9;
    bus_clock_i <= 1'b1;
    hold_acknowledge_out_i <= 1'b1;
    write_strobe_low_i <= 1'b1;
    read_strobe_i <= 1'b1;
    address_strobe_i <= 1'b1;
    upper_address_i <= 2'h2;
    apb(1'b1, CTRL_MODE_OFS, 32'hf);
    apb(1'b1, STROBE_MODE_OFS, 32'hff);
    apb(1'b1, UPPER_MODE_OFS, 32'h3);
    apb(1'b0, STROBE_MODE_OFS, 32'h0);
    chk(rdata, 32'h53, "strobe mode bits");
    settle();
    chk(ctrl_pin_o & 4'h6, 4'h6, "clock and hold ack out");
    chk(ctrl_pin_oe_n_o, 4'h9, "control enables");
    chk({bus_wait_o, hold_request_in_o}, 2'h3, "wait and hold in");
    chk(strobe_pin_o & 8'h53, 8'h51, "strobes out");
    chk(strobe_pin_oe_n_o & 8'h53, 8'h00, "strobes driven");
    chk({upper_addr_pin_oe_n_o, upper_addr_pin_o}, 4'h2, "upper address out");
    @(posedge clk_sys_i);
    write_strobe_low_i <= 1'b0;
    write_strobe_high_i <= 1'b1;
    upper_address_i <= 2'h1;
    settle();
    chk(strobe_pin_o & 8'h53, 8'h52, "strobes follow");
    chk(upper_addr_pin_o, 2'h1, "upper address follows");
    // With the clock enable low the pins hold; raising it lets them follow again.
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    write_strobe_high_i <= 1'b0;
    settle();
    chk(strobe_pin_o & 8'h53, 8'h52, "held while disabled");
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    settle();
    chk(strobe_pin_o & 8'h53, 8'h50, "strobes after enable");
    apb(1'b1, CTRL_MODE_OFS, 32'h0);
    settle();
    chk(bus_wait_o, 1'b0, "wait gated in port mode");
    chk(ctrl_pin_oe_n_o, 4'hf, "control pins float");
  endtask : t_ext

  // Unmapped, missing and misaligned places are refused; the missing register also reads as zero.
  task automatic t_bad;
    apb(1'b1, MAP_END, 32'hffff);
    chk(err, 1'b1, "unmapped write");
    apb(1'b0, 8'h0c, 32'h0);
    chk(err, 1'b1, "missing register refused");
    chk(rdata, 32'h0, "missing register read");
    apb(1'b0, 8'h01, 32'h0);
    chk(err, 1'b1, "misaligned read");
  endtask : t_bad

  // Main sequence: reset for 12 cycles, then each scenario in turn.
  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_port();
    t_alt_low();
    t_ext();
    t_bad();
    end_of_test();
  end
endmodule : port_alt_function_mux_tb
`default_nettype wire
